/* File: design/pllsw_switchover.sv */
// module: reference clock switchover with edge sensing, sequencer and ahb-lite registers
`timescale 1ns/1ns

module pllsw_switchover #(
  parameter bit AUTO_CAPABLE = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ref_clock_primary,
  input wire logic ref_clock_secondary,
  input wire logic switch_request,
  input wire logic lock_ungated,
  input wire logic lock_gated,
  output logic ref_select,
  output logic ref_gated_off,
  output logic primary_missing_flag,
  output logic secondary_missing_flag,
  output logic switch_condition_flag,
  output logic active_clock
);
  import pllsw_pkg::*;

  localparam int NSYNC = 5;

  typedef enum {
    SW_IDLE,
    SW_HOLD,
    SW_GATE,
    SW_MOVE
  } pllsw_state_t;

  // pin inputs, three flops each; stage one feeds only stage two
  logic [NSYNC-1:0] sync_a;
  logic [NSYNC-1:0] sync_b;
  logic [NSYNC-1:0] sync_prev;
  logic [NSYNC-1:0] pin_in;
  assign pin_in = {lock_gated, lock_ungated, switch_request, ref_clock_secondary,
                   ref_clock_primary};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // two-stage synchroniser plus a history flop for edges
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_prev[gi] <= 1'b0;
        end else if (clk_en) begin
          sync_a[gi] <= pin_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_prev[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate

  // rising and falling edges of the synchronised lines
  logic [NSYNC-1:0] rise;
  logic [NSYNC-1:0] fall;
  assign rise = sync_b & ~sync_prev;
  assign fall = ~sync_b & sync_prev;

  logic req_level;
  logic sw_enable;
  assign req_level = sync_b[2];
  assign sw_enable = sync_b[4] & ~sync_b[3];

  logic sw_enable_prev;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_enable_prev <= 1'b0;
    end else if (clk_en) begin
      sw_enable_prev <= sw_enable;
    end
  end

  // picks one of the two per-reference bits (edges or missing flags) by index
  function automatic logic pick(input logic [1:0] v, input logic idx);
    pick = idx ? v[1] : v[0];
  endfunction : pick

  // control and status storage
  pllsw_ctrl_t ctrl;
  pllsw_mode_t mode_eff;
  assign mode_eff = AUTO_CAPABLE ? ctrl.mode : PLLSW_MODE_MANUAL;

  // edge counters per reference; a lone clock counting to three marks the other dead
  logic [1:0] cnt0;
  logic [1:0] cnt1;
  logic [1:0] next_cnt0;
  logic [1:0] next_cnt1;
  logic miss0;
  logic miss1;
  logic set_miss0;
  logic set_miss1;
  always_comb begin
    next_cnt0 = cnt0 + {1'b0, rise[0]};
    next_cnt1 = cnt1 + {1'b0, rise[1]};
    set_miss0 = 1'b0;
    set_miss1 = 1'b0;
    if (next_cnt0 >= PLLSW_EDGE_ONE && next_cnt1 >= PLLSW_EDGE_ONE) begin
      next_cnt0 = 2'h0;
      next_cnt1 = 2'h0;
    end else if (next_cnt0 == PLLSW_EDGE_MISS) begin
      set_miss1 = 1'b1;
      next_cnt0 = 2'h0;
    end else if (next_cnt1 == PLLSW_EDGE_MISS) begin
      set_miss0 = 1'b1;
      next_cnt1 = 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt0 <= 2'h0;
      cnt1 <= 2'h0;
    end else if (clk_en) begin
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
    end
  end

  // missing flags: set wins over the clear by a returning edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss0 <= 1'b0;
      miss1 <= 1'b0;
    end else if (clk_en) begin
      if (set_miss0) begin
        miss0 <= 1'b1;
      end else if (rise[0]) begin
        miss0 <= 1'b0;
      end
      if (set_miss1) begin
        miss1 <= 1'b1;
      end else if (rise[1]) begin
        miss1 <= 1'b0;
      end
    end
  end

  // switch triggers per mode
  pllsw_state_t state;
  logic sel;
  logic trigger;
  logic cur_missing;
  assign cur_missing = pick({miss1, miss0}, sel);
  always_comb begin
    case (mode_eff)
      PLLSW_MODE_MANUAL: trigger = req_level != sel;
      // rising edge only; a falling request is ignored here
      PLLSW_MODE_AUTO: trigger = rise[2] | (!sel && miss0);
      PLLSW_MODE_LOCK: trigger = sw_enable & ~sw_enable_prev;
      default: trigger = 1'b0;
    endcase
  end

  // switchover sequencer: hold off, gate, then move on a clean target edge
  logic [PLLSW_DELAY_W-1:0] delay_cnt;
  logic gate;
  logic target_rise;
  assign target_rise = pick(rise[1:0], ~sel);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SW_IDLE;
      sel <= 1'b0;
      gate <= 1'b0;
      delay_cnt <= '0;
    end else if (clk_en) begin
      case (state)
        SW_IDLE: begin
          delay_cnt <= '0;
          if (trigger) begin
            state <= (ctrl.delay_en && mode_eff != PLLSW_MODE_MANUAL) ? SW_HOLD : SW_GATE;
          end
        end
        // counted in target edges, so a dead target also stalls here
        SW_HOLD: begin
          if (target_rise) begin
            delay_cnt <= delay_cnt + 1'b1;
            if (delay_cnt == ctrl.delay_val) begin
              state <= SW_GATE;
            end
          end
        end
        // a stopped current clock has no falling edge left to wait for
        SW_GATE: begin
          if (pick(fall[1:0], sel) || cur_missing) begin
            gate <= 1'b1;
            state <= SW_MOVE;
          end
        end
        SW_MOVE: begin
          if (target_rise && !pick({miss1, miss0}, ~sel)) begin
            sel <= ~sel;
            gate <= 1'b0;
            state <= SW_IDLE;
          end
        end
        default: state <= SW_IDLE;
      endcase
    end
  end

  // fabric-facing outputs, all from flops; absent flags held low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_select <= 1'b0;
      ref_gated_off <= 1'b0;
      primary_missing_flag <= 1'b0;
      secondary_missing_flag <= 1'b0;
      switch_condition_flag <= 1'b0;
      active_clock <= 1'b0;
    end else if (clk_en) begin
      ref_select <= sel;
      ref_gated_off <= gate;
      primary_missing_flag <= AUTO_CAPABLE & miss0;
      secondary_missing_flag <= AUTO_CAPABLE & miss1;
      switch_condition_flag <= AUTO_CAPABLE & (trigger | cur_missing | (state != SW_IDLE));
      active_clock <= AUTO_CAPABLE & sel;
    end
  end

  pllsw_status_t status;
  assign status = '{primary_missing: primary_missing_flag,
                    secondary_missing: secondary_missing_flag,
                    switch_cond: switch_condition_flag,
                    active: active_clock,
                    gated: gate,
                    busy: state != SW_IDLE,
                    select: sel};

  // ahb-lite slave: every transfer gets one wait state, then an okay
  logic pend;
  logic pend_write;
  logic [7:0] pend_addr;
  logic take;
  assign take = hsel && htrans[1] && hready;

  // read mux for a word offset
  function automatic logic [31:0] read_word(input logic [7:0] ofs, input pllsw_ctrl_t c,
                                            input pllsw_status_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (ofs)
      PLLSW_CTRL_OFS: begin
        w[PLLSW_CTRL_MODE_LSB +: 2] = c.mode;
        w[PLLSW_CTRL_DELAY_EN_BIT] = c.delay_en;
        w[PLLSW_CTRL_DELAY_LSB +: PLLSW_DELAY_W] = c.delay_val;
      end
      PLLSW_STATUS_OFS: begin
        w[PLLSW_STAT_PRI_MISS_BIT] = s.primary_missing;
        w[PLLSW_STAT_SEC_MISS_BIT] = s.secondary_missing;
        w[PLLSW_STAT_COND_BIT] = s.switch_cond;
        w[PLLSW_STAT_ACTIVE_BIT] = s.active;
        w[PLLSW_STAT_GATED_BIT] = s.gated;
        w[PLLSW_STAT_BUSY_BIT] = s.busy;
        w[PLLSW_STAT_SELECT_BIT] = s.select;
      end
      default: w = 32'h0000_0000;
    endcase
    read_word = w;
  endfunction : read_word

  // bus handshake and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      hresp <= 1'b0;
      if (pend) begin
        pend <= 1'b0;
        hreadyout <= 1'b1;
        if (!pend_write) begin
          hrdata <= read_word(pend_addr, ctrl, status);
        end
      end else if (take) begin
        pend <= 1'b1;
        pend_write <= hwrite;
        pend_addr <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;
      end
    end
  end

  // control register write, taken in the first data-phase cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= pllsw_ctrl_t'(PLLSW_CTRL_RESET[7:0]);
    end else if (clk_en) begin
      if (pend && pend_write && pend_addr == PLLSW_CTRL_OFS) begin
        ctrl.mode <= pllsw_mode_t'(hwdata[PLLSW_CTRL_MODE_LSB +: 2]);
        ctrl.delay_en <= hwdata[PLLSW_CTRL_DELAY_EN_BIT];
        ctrl.delay_val <= hwdata[PLLSW_CTRL_DELAY_LSB +: PLLSW_DELAY_W];
      end
    end
  end

endmodule : pllsw_switchover

/* File: design/pllsw_pkg.sv */
// package: register map, fields, reset values and carrier types of the switchover block
package pllsw_pkg;

  // register byte offsets
  localparam logic [7:0] PLLSW_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLLSW_STATUS_OFS = 8'h04;

  // control register fields
  localparam int PLLSW_CTRL_MODE_LSB = 0;
  localparam int PLLSW_CTRL_DELAY_EN_BIT = 2;
  localparam int PLLSW_CTRL_DELAY_LSB = 8;
  localparam logic [31:0] PLLSW_CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int PLLSW_STAT_PRI_MISS_BIT = 0;
  localparam int PLLSW_STAT_SEC_MISS_BIT = 1;
  localparam int PLLSW_STAT_COND_BIT = 2;
  localparam int PLLSW_STAT_ACTIVE_BIT = 3;
  localparam int PLLSW_STAT_GATED_BIT = 4;
  localparam int PLLSW_STAT_BUSY_BIT = 5;
  localparam int PLLSW_STAT_SELECT_BIT = 6;

  // hold-off counter width and edge-count limits
  localparam int PLLSW_DELAY_W = 5;
  localparam logic [1:0] PLLSW_EDGE_MISS = 2'h3;
  localparam logic [1:0] PLLSW_EDGE_ONE = 2'h1;

  // timing of the bus clock
  localparam int PLLSW_HCLK_PERIOD_NS = 4;
  localparam int PLLSW_SYNC_STAGES = 2;

  // switching modes as written to the control register
  typedef enum logic [1:0] {
    PLLSW_MODE_MANUAL = 2'h0,
    PLLSW_MODE_AUTO = 2'h1,
    PLLSW_MODE_LOCK = 2'h2,
    PLLSW_MODE_RSVD = 2'h3
  } pllsw_mode_t;

  // software control carried as one word
  typedef struct packed {
    pllsw_mode_t mode;
    logic delay_en;
    logic [PLLSW_DELAY_W-1:0] delay_val;
  } pllsw_ctrl_t;

  // status carried to the register file; the flags come from the fabric-facing flops, while gated, busy and select come from the sequencer
  typedef struct packed {
    logic primary_missing;
    logic secondary_missing;
    logic switch_cond;
    logic active;
    logic gated;
    logic busy;
    logic select;
  } pllsw_status_t;

endpackage : pllsw_pkg

/* File: verif/pllsw_fabric.sv */
// fabric model: drives the switch request the way user logic must
`timescale 1ns/1ns
module pllsw_fabric #(
  parameter int MINW = 40
) (
  input wire logic hclk,
  input wire logic want,
  input wire logic pri_bad,
  input wire logic sec_bad,
  input wire logic active,
  input wire logic lock,
  output logic switch_request,
  output logic pfd_enable,
  output logic pll_reset,
  output logic out_enable
);
  int hold;
  int rst_cnt;
  logic last_active;
  initial begin
    switch_request = 1'b0;
    hold = 0;
    rst_cnt = 0;
    last_active = 1'b0;
    pfd_enable = 1'b0;
    pll_reset = 1'b0;
    out_enable = 1'b0;
  end
  // each level stands long enough for the slower reference to follow
  always @(posedge hclk) begin
    if (hold > 0) begin
      hold <= hold - 1;
    end else if (want != switch_request && !(want && (pri_bad || sec_bad))) begin
      switch_request <= want;
      hold <= MINW;
    end
  end
  // phase detector off while a reference is flagged missing, so the loop holds
  always @(posedge hclk) begin
    pfd_enable <= !(pri_bad || sec_bad);
  end
  // after a switch: reset pulse of 4 cycles (16 ns, above 10 ns), outputs off till lock
  always @(posedge hclk) begin
    last_active <= active;
    if (active != last_active) begin
      rst_cnt <= 3;
    end else if (rst_cnt > 0) begin
      rst_cnt <= rst_cnt - 1;
    end
    pll_reset <= (active != last_active) || (rst_cnt > 0);
    out_enable <= lock && !pll_reset && (active == last_active);
  end
endmodule : pllsw_fabric

/* File: verif/pllsw_switchover_monitor.sv */
// checker: bus timing and switchover sequencing
`timescale 1ns/1ns
module pllsw_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic ref_select,
  input wire logic ref_gated_off,
  input wire logic primary_missing_flag,
  input wire logic switch_condition_flag,
  input wire logic active_clock
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // bus: one wait state, okay, read data held
  a_one_wait: assert property (hsel && htrans[1] && hready && hreadyout && clk_en
    |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
  a_resp_okay: assert property (!hresp) else $error("resp not okay");
  a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
    else $error("rdata moved");
  // mux moves only from the gated state, with the indicator
  a_act_mux: assert property (active_clock == ref_select)
    else $error("active differs");
  a_gate_first: assert property ($changed(ref_select) |-> $past(ref_gated_off))
    else $error("mux moved ungated");
  a_gate_ends: assert property ($changed(ref_select) |-> !ref_gated_off)
    else $error("gate held");
  a_cond_cause: assert property ($changed(ref_select) |-> $past(switch_condition_flag))
    else $error("switch without cond");
  a_gate_cond: assert property (ref_gated_off |-> switch_condition_flag)
    else $error("gated without cond");
  a_miss_cond: assert property (primary_missing_flag && !active_clock
    |-> ##[0:2] switch_condition_flag) else $error("miss without cond");
  c_to_sec: cover property ($rose(active_clock));
  c_to_pri: cover property ($fell(active_clock));
  c_missing: cover property ($rose(primary_missing_flag));
endmodule : pllsw_monitor

bind pllsw_switchover pllsw_monitor i_mon (.hclk, .hresetn, .clk_en, .hsel, .htrans,
  .hready, .hreadyout, .hresp, .hrdata, .ref_select, .ref_gated_off,
  .primary_missing_flag, .switch_condition_flag, .active_clock);

/* File: verif/pll_ref_clock_switchover_test.sv */
// testbench: switchover block over the bus and a fabric model
`timescale 1ns/1ns
module pll_ref_clock_switchover_test;
  import pllsw_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, seed;
  logic hreadyout, sel, act, pmiss, smiss, sreq, pfd_en, out_en;
  time t0, dt;
  logic rcp = 1'b0, rcs = 1'b0, run_p = 1'b1;
  logic want = 1'b0, lock_u = 1'b1, lock_g = 1'b0;
  int error_cnt = 0;
  int n_tests = 0;
  int m_act = 0;
  int m_ctrl = 0;
  // references stay below hclk/2, unrelated in phase
  always #2 hclk = ~hclk;
  always #15 rcp = run_p ? ~rcp : rcp;
  always #18 rcs = ~rcs;
  pllsw_switchover i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .ref_clock_primary(rcp), .ref_clock_secondary(rcs), .switch_request(sreq),
    .lock_ungated(lock_u), .lock_gated(lock_g), .ref_select(sel), .ref_gated_off(),
    .primary_missing_flag(pmiss), .secondary_missing_flag(smiss),
    .switch_condition_flag(), .active_clock(act));
  pllsw_fabric #(.MINW(40)) i_fab (.hclk(hclk), .want(want), .pri_bad(pmiss),
    .sec_bad(smiss), .active(act), .lock(lock_u), .switch_request(sreq),
    .pfd_enable(pfd_en), .pll_reset(), .out_enable(out_en));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // mux and indicator against the model
  task automatic chk_act;
    chk({30'h0, sel, act}, {30'h0, m_act[0], m_act[0]});
  endtask : chk_act
  // single word transfer; each phase held until hready is seen high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge hclk);
      k++;
    end while (!hreadyout && k < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      k++;
    end while (!hreadyout && k < 50);
    r = hrdata;
    if (k >= 50) begin
      error_cnt++;
      end_of_test;
    end
  endtask : bus
  // bounded wait on the indicator (s=0) or the primary flag (s=1)
  task automatic wait_on(input int s, input logic v);
    int k;
    for (k = 0; k < 5000; k++) begin
      @(posedge hclk);
      if (((s == 0) ? act : pmiss) === v) break;
    end
    if (k >= 5000) begin
      error_cnt++;
      end_of_test;
    end
  endtask : wait_on
  initial begin
    seed = 32'h8179;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 32'h0, 32'h0, rd);
    chk(rd, m_ctrl);
    bus(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0);
    // manual: request level picks the reference, both ways
    want <= 1'b1;
    m_act = 1;
    wait_on(0, 1'b1);
    chk_act();
    want <= 1'b0;
    m_act = 0;
    wait_on(0, 1'b0);
    chk_act();
    // auto: primary stops, flag rises and the secondary takes over
    m_ctrl = 1;
    bus(1'b1, 32'h0, 32'(m_ctrl), rd);
    run_p <= 1'b0;
    m_act = 1;
    wait_on(0, 1'b1);
    chk_act();
    bus(1'b0, 32'h4, 32'h0, rd);
    // primary missing, no condition left, active and select on secondary, not gated or busy
    chk(rd & 32'h0000_007F, 32'h0000_0049);
    chk({31'h0, pfd_en}, 32'h0);
    // primary back; override on rise only
    run_p <= 1'b1;
    wait_on(1, 1'b0);
    want <= 1'b1;
    m_act = 0;
    wait_on(0, 1'b0);
    chk_act();
    want <= 1'b0;
    repeat (200) @(posedge hclk);
    chk_act();
    chk({31'h0, out_en}, 32'h1);
    // random control words read back through the writable fields
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, 32'h0, seed, rd);
      bus(1'b0, 32'h0, 32'h0, rd);
      chk(rd & 32'h0000_1F07, seed & 32'h0000_1F07);
    end
    // lock mode with hold-off: no switch until the gated lock is up
    m_ctrl = 32'({seed[4:0], 8'h06});
    bus(1'b1, 32'h0, 32'(m_ctrl), rd);
    lock_u <= 1'b0;
    repeat (300) @(posedge hclk);
    chk_act();
    t0 = $time;
    lock_g <= 1'b1;
    m_act = 1;
    wait_on(0, 1'b1);
    chk_act();
    // hold-off spans the delay value in target periods (36 ns), plus gate and move
    dt = $time - t0;
    chk(32'(dt >= 36 * m_ctrl[12:8] && dt <= 36 * (m_ctrl[12:8] + 5)), 32'h1);
    chk({31'h0, out_en}, 32'h0);
    end_of_test;
  end
endmodule : pll_ref_clock_switchover_test
